/* File: logic/fid_exc_map.vh */
// constants of the invalid-operation and denormal exception unit
// assumes a 32-bit avalon slave decode with byte addresses
//
// Functional notes
// - invalid condition lands in status bit 0, masked by control bit 0.
// - stack overflow or underflow sets invalid and stack fault bit 6.
// - invalid operand never clears stack fault; older one stays visible.
// - load from memory into non-empty register (tag 00,01,10) is overflow.
// - any source naming empty register (tag 11) is underflow, stores too.
// - stack fault writes cond code 1 (bit 9): one overflow, zero underflow.
// - masked stack fault writes float, integer or bcd indefinite as fitting.
// - unmasked invalid calls handler; top pointer and sources stay untouched.
// - invalid operand sets flag; masked gives indefinite, nan or condition codes.
// - quiet nan alone raises nothing, except unmasked ordered compares.
// - masked unsupported, inf-inf, inf times zero, inf/inf, 0/0 give indefinite.
// - masked arithmetic on signaling nan gives quiet nan.
// - masked ordered compare or test with nan sets unordered 111.
// - masked remainder or trig faults give indefinite and clear cond code 2.
// - masked negative root, negative log, log-plus-one below -1 give indefinite.
// - masked bcd store beyond 18 digits writes bcd indefinite.
// - masked integer store out of range writes integer indefinite.
// - masked exchange fills empty registers with indefinite, then exchanges.
// - denormal raised on arithmetic or single/double load, not extended load.
// - denormal condition in status bit 1, masked by control bit 1.
// - masked denormal sets flag, continues, normalizes on conversion.
// - unmasked denormal sets flag, calls handler, keeps top and sources.
// - summary flag set whenever any exception is detected.
`ifndef FID_EXC_MAP_VH
`define FID_EXC_MAP_VH

`define FID_ADDR_STATUS  4'h0
`define FID_ADDR_CONTROL 4'h4
`define FID_ADDR_RESP    4'h8

`define FID_ST_INV   0
`define FID_ST_DEN   1
`define FID_ST_SF    6
`define FID_ST_ES    7
`define FID_ST_CC0   8
`define FID_ST_CC1   9
`define FID_ST_CC2   10
`define FID_ST_CC3   14
`define FID_CW_IM    0
`define FID_CW_DM    1

`define FID_STATUS_RST  16'h0000
`define FID_CONTROL_RST 16'h0003

`define FID_TAG_EMPTY 2'h3

`define FID_CL_UNSUP 7
`define FID_CL_SNAN  6
`define FID_CL_QNAN  5
`define FID_CL_INF   4
`define FID_CL_ZERO  3
`define FID_CL_DEN   2
`define FID_CL_NEG   1
`define FID_CL_LTM1  0

`define FID_OP_ADD      5'h00
`define FID_OP_SUB      5'h01
`define FID_OP_MUL      5'h02
`define FID_OP_DIV      5'h03
`define FID_OP_CMP      5'h04
`define FID_OP_CMP_P    5'h05
`define FID_OP_CMP_PP   5'h06
`define FID_OP_CMPI     5'h07
`define FID_OP_CMPI_P   5'h08
`define FID_OP_UCMP     5'h09
`define FID_OP_TEST     5'h0A
`define FID_OP_PREM     5'h0B
`define FID_OP_PREM1    5'h0C
`define FID_OP_COS      5'h0D
`define FID_OP_PTAN     5'h0E
`define FID_OP_SIN      5'h0F
`define FID_OP_SINCOS   5'h10
`define FID_OP_SQRT     5'h11
`define FID_OP_YL2X     5'h12
`define FID_OP_YL2XP1   5'h13
`define FID_OP_BCD_ST   5'h14
`define FID_OP_INT_ST   5'h15
`define FID_OP_FP_ST    5'h16
`define FID_OP_XCHG     5'h17
`define FID_OP_LOAD     5'h18

`define FID_RES_NONE     3'h0
`define FID_RES_QNAN_IND 3'h1
`define FID_RES_QUIET    3'h2
`define FID_RES_INT_IND  3'h3
`define FID_RES_BCD_IND  3'h4

`endif

/* File: logic/fid_opnd_chk.v */
// classifies one operand against its tag and value class
// assumes class bits are one-hot-ish from the pipeline's decoder
`include "fid_exc_map.vh"
`default_nettype none

module fid_opnd_chk (
  input  wire       present,
  input  wire       from_stack,
  input  wire [1:0] tag,
  input  wire [7:0] cls,
  output wire       empty,
  output wire       nan,
  output wire       snan,
  output wire       qnan,
  output wire       inf,
  output wire       zero,
  output wire       den,
  output wire       unsup,
  output wire       neg,
  output wire       ltm1
);

  assign empty = present & from_stack & (tag == `FID_TAG_EMPTY);
  // empty registers hold no value worth classifying
  wire live = present & ~empty;
  assign snan  = live & cls[`FID_CL_SNAN];
  assign qnan  = live & cls[`FID_CL_QNAN];
  assign nan   = snan | qnan;
  assign inf   = live & cls[`FID_CL_INF];
  assign zero  = live & cls[`FID_CL_ZERO];
  assign den   = live & cls[`FID_CL_DEN];
  assign unsup = live & cls[`FID_CL_UNSUP];
  assign neg   = live & cls[`FID_CL_NEG];
  assign ltm1  = live & cls[`FID_CL_LTM1];

endmodule
`default_nettype wire

/* File: logic/fid_exc.v */
// invalid-operation and denormal exception unit with status/control words
// assumes pipeline presents one check per op_valid pulse, avalon master on bus
`include "fid_exc_map.vh"
`default_nettype none

module fid_exc (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire        load_ext,
  input  wire [1:0]  dst_tag,
  input  wire        a_present,
  input  wire        a_from_stack,
  input  wire [1:0]  a_tag,
  input  wire [7:0]  a_class,
  input  wire        b_present,
  input  wire        b_from_stack,
  input  wire [1:0]  b_tag,
  input  wire [7:0]  b_class,
  input  wire        bcd_over,
  input  wire        int_over,
  output reg         rsp_valid_r,
  output reg         rsp_trap_r,
  output reg         rsp_commit_r,
  output reg  [2:0]  rsp_result_r,
  output reg         rsp_fill_a_r,
  output reg         rsp_fill_b_r,
  output reg         rsp_normalize_r,
  output reg         rsp_eflags_wr_r,
  output reg  [2:0]  rsp_eflags_r,
  output reg  [15:0] status_word_r,
  output reg  [15:0] control_word_r
);

  function is_op;
    input [4:0] code;
    input [4:0] want;
    begin
      is_op = (code == want);
    end
  endfunction

  wire a_empty, a_nan, a_snan, a_qnan, a_inf, a_zero, a_den, a_unsup, a_neg, a_ltm1;
  wire b_empty, b_nan, b_snan, b_qnan, b_inf, b_zero, b_den, b_unsup, b_neg, b_ltm1;

  fid_opnd_chk u_chk_a (
    .present    (a_present),
    .from_stack (a_from_stack),
    .tag        (a_tag),
    .cls        (a_class),
    .empty      (a_empty),
    .nan        (a_nan),
    .snan       (a_snan),
    .qnan       (a_qnan),
    .inf        (a_inf),
    .zero       (a_zero),
    .den        (a_den),
    .unsup      (a_unsup),
    .neg        (a_neg),
    .ltm1       (a_ltm1)
  );

  fid_opnd_chk u_chk_b (
    .present    (b_present),
    .from_stack (b_from_stack),
    .tag        (b_tag),
    .cls        (b_class),
    .empty      (b_empty),
    .nan        (b_nan),
    .snan       (b_snan),
    .qnan       (b_qnan),
    .inf        (b_inf),
    .zero       (b_zero),
    .den        (b_den),
    .unsup      (b_unsup),
    .neg        (b_neg),
    .ltm1       (b_ltm1)
  );

  wire inv_mask = control_word_r[`FID_CW_IM];
  wire den_mask = control_word_r[`FID_CW_DM];

  wire op_xchg = is_op(op_code, `FID_OP_XCHG);
  wire op_load = is_op(op_code, `FID_OP_LOAD);
  wire op_bcd  = is_op(op_code, `FID_OP_BCD_ST);
  wire op_ist  = is_op(op_code, `FID_OP_INT_ST);
  wire op_cmpi = is_op(op_code, `FID_OP_CMPI) | is_op(op_code, `FID_OP_CMPI_P);
  wire op_ord  = is_op(op_code, `FID_OP_CMP) | is_op(op_code, `FID_OP_CMP_P) |
                 is_op(op_code, `FID_OP_CMP_PP) | op_cmpi;
  wire op_cmp_any = op_ord | is_op(op_code, `FID_OP_TEST) | is_op(op_code, `FID_OP_UCMP);
  wire op_rem  = is_op(op_code, `FID_OP_PREM) | is_op(op_code, `FID_OP_PREM1);
  wire op_trig = is_op(op_code, `FID_OP_COS) | is_op(op_code, `FID_OP_PTAN) |
                 is_op(op_code, `FID_OP_SIN) | is_op(op_code, `FID_OP_SINCOS);

  // extended loads and exchanges move bits without touching them
  wire arith = ~op_xchg & ~(op_load & load_ext);

  reg        ovf;
  reg        unf;
  reg        stk_fault;
  reg        ia;
  reg        unord;
  reg        den_ev;
  reg        inv_ev;
  reg        trap;
  reg [2:0]  res_code;
  reg        cc1_wr;
  reg        cc2_clr;
  reg        cc_unord_wr;
  reg        efl_wr;

  always @* begin
    ovf = op_load & (dst_tag != `FID_TAG_EMPTY);
    unf = a_empty | b_empty;
    stk_fault = ovf | unf;
    ia = 1'b0;
    if (!stk_fault && arith) begin
      ia = a_unsup | b_unsup;
      if (is_op(op_code, `FID_OP_ADD))
        ia = ia | (a_inf & b_inf & (a_neg ^ b_neg));
      if (is_op(op_code, `FID_OP_SUB))
        ia = ia | (a_inf & b_inf & ~(a_neg ^ b_neg));
      if (is_op(op_code, `FID_OP_MUL))
        ia = ia | (a_inf & b_zero) | (a_zero & b_inf);
      if (is_op(op_code, `FID_OP_DIV))
        ia = ia | (a_inf & b_inf) | (a_zero & b_zero);
      ia = ia | a_snan | b_snan;
      // quiet nan only for unmasked ordered compares
      ia = ia | (op_ord & (a_qnan | b_qnan) & ~inv_mask);
      ia = ia | (op_rem & (b_zero | a_inf)) | (op_trig & a_inf);
      if (is_op(op_code, `FID_OP_SQRT) || is_op(op_code, `FID_OP_YL2X))
        ia = ia | (a_neg & ~a_zero);
      if (is_op(op_code, `FID_OP_YL2XP1))
        ia = ia | a_ltm1;
      ia = ia | (op_bcd & bcd_over);
      ia = ia | (op_ist & int_over);
    end
    inv_ev = op_valid & (stk_fault | ia);
    den_ev = op_valid & arith & ~stk_fault & ~ia & (a_den | b_den);
    trap = (inv_ev & ~inv_mask) | (den_ev & ~den_mask);
    unord = op_valid & ~stk_fault & ~trap & (op_ord | is_op(op_code, `FID_OP_TEST)) &
            (a_nan | b_nan);
    cc_unord_wr = unord & ~op_cmpi;
    efl_wr = unord & op_cmpi;
    // cond code 1 on any stack fault
    cc1_wr = op_valid & stk_fault;
    cc2_clr = op_valid & ia & inv_mask & (op_rem | op_trig);
    res_code = `FID_RES_NONE;
    if (inv_ev && inv_mask && !op_cmp_any && !op_xchg) begin
      if (op_bcd)
        res_code = `FID_RES_BCD_IND;
      else if (op_ist)
        res_code = `FID_RES_INT_IND;
      else if (!stk_fault && (a_snan | b_snan) && !(a_unsup | b_unsup))
        res_code = `FID_RES_QUIET;
      else
        res_code = `FID_RES_QNAN_IND;
    end
  end

  // avalon slave: one wait cycle, then a single low-wait cycle
  wire       bus_req  = avs_read | avs_write;
  wire       bus_done = ~avs_waitrequest & bus_req;
  wire       wr_done  = bus_done & avs_write;
  wire [15:0] wr_lane = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire       wr_stat  = wr_done & (avs_address == `FID_ADDR_STATUS);
  wire       wr_ctrl  = wr_done & (avs_address == `FID_ADDR_CONTROL);
  wire [15:0] w1c     = wr_stat ? (avs_writedata[15:0] & wr_lane) : 16'h0000;

  reg [15:0] status_nxt;
  reg [2:0]  last_res_r;
  reg        last_trap_r;

  always @* begin
    status_nxt = status_word_r;
    // sticky flags: software clears by writing one, hardware set wins
    status_nxt[`FID_ST_INV] = status_word_r[`FID_ST_INV] & ~w1c[`FID_ST_INV];
    status_nxt[`FID_ST_DEN] = status_word_r[`FID_ST_DEN] & ~w1c[`FID_ST_DEN];
    status_nxt[`FID_ST_SF]  = status_word_r[`FID_ST_SF]  & ~w1c[`FID_ST_SF];
    status_nxt[`FID_ST_ES]  = status_word_r[`FID_ST_ES]  & ~w1c[`FID_ST_ES];
    if (wr_stat && avs_byteenable[1]) begin
      status_nxt[`FID_ST_CC0] = avs_writedata[`FID_ST_CC0];
      status_nxt[`FID_ST_CC1] = avs_writedata[`FID_ST_CC1];
      status_nxt[`FID_ST_CC2] = avs_writedata[`FID_ST_CC2];
      status_nxt[`FID_ST_CC3] = avs_writedata[`FID_ST_CC3];
    end
    if (inv_ev)
      status_nxt[`FID_ST_INV] = 1'b1;
    // invalid operand leaves stack fault alone
    if (op_valid && stk_fault)
      status_nxt[`FID_ST_SF] = 1'b1;
    if (den_ev)
      status_nxt[`FID_ST_DEN] = 1'b1;
    if (inv_ev || den_ev)
      status_nxt[`FID_ST_ES] = 1'b1;
    if (cc1_wr)
      status_nxt[`FID_ST_CC1] = ovf;
    if (cc2_clr)
      status_nxt[`FID_ST_CC2] = 1'b0;
    if (cc_unord_wr) begin
      status_nxt[`FID_ST_CC0] = 1'b1;
      status_nxt[`FID_ST_CC2] = 1'b1;
      status_nxt[`FID_ST_CC3] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_word_r   <= `FID_STATUS_RST;
      control_word_r  <= `FID_CONTROL_RST;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      last_res_r      <= `FID_RES_NONE;
      last_trap_r     <= 1'b0;
    end else begin
      status_word_r <= status_nxt;
      if (wr_ctrl)
        control_word_r <= (control_word_r & ~wr_lane) | (avs_writedata[15:0] & wr_lane);
      avs_waitrequest <= ~(avs_waitrequest & bus_req);
      if (avs_waitrequest && avs_read) begin
        case (avs_address)
          `FID_ADDR_STATUS:  avs_readdata <= {16'h0000, status_word_r};
          `FID_ADDR_CONTROL: avs_readdata <= {16'h0000, control_word_r};
          `FID_ADDR_RESP:    avs_readdata <= {28'h0000000, last_trap_r, last_res_r};
          default:           avs_readdata <= 32'h00000000;
        endcase
      end
      if (op_valid) begin
        last_res_r  <= res_code;
        last_trap_r <= trap;
      end
    end
  end

  // response toward the pipeline, one cycle after op_valid
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_r     <= 1'b0;
      rsp_trap_r      <= 1'b0;
      rsp_commit_r    <= 1'b0;
      rsp_result_r    <= `FID_RES_NONE;
      rsp_fill_a_r    <= 1'b0;
      rsp_fill_b_r    <= 1'b0;
      rsp_normalize_r <= 1'b0;
      rsp_eflags_wr_r <= 1'b0;
      rsp_eflags_r    <= 3'h0;
    end else begin
      rsp_valid_r  <= op_valid;
      rsp_trap_r   <= trap;
      // no top or source update on trap
      rsp_commit_r <= op_valid & ~trap;
      rsp_result_r <= res_code;
      rsp_fill_a_r <= op_valid & op_xchg & inv_mask & a_empty;
      rsp_fill_b_r <= op_valid & op_xchg & inv_mask & b_empty;
      rsp_normalize_r <= den_ev & den_mask & ~trap;
      rsp_eflags_wr_r <= efl_wr;
      rsp_eflags_r    <= efl_wr ? 3'h7 : 3'h0;
    end
  end

endmodule
`default_nettype wire

/* File: tb/fid_exc_props.sv */
// port-level assertions for the invalid and denormal exception unit
// assumes one clock domain, responses one edge after op_valid
`include "fid_exc_map.vh"
`default_nettype none
module fid_exc_props (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        op_valid,
  input wire logic [4:0]  op_code,
  input wire logic [1:0]  dst_tag,
  input wire logic        a_present,
  input wire logic        a_from_stack,
  input wire logic [1:0]  a_tag,
  input wire logic [7:0]  a_class,
  input wire logic        b_present,
  input wire logic        b_from_stack,
  input wire logic [1:0]  b_tag,
  input wire logic [7:0]  b_class,
  input wire logic        rsp_valid_r,
  input wire logic        rsp_trap_r,
  input wire logic        rsp_commit_r,
  input wire logic [2:0]  rsp_result_r,
  input wire logic        rsp_fill_a_r,
  input wire logic        rsp_eflags_wr_r,
  input wire logic [2:0]  rsp_eflags_r,
  input wire logic [15:0] status_word_r,
  input wire logic [15:0] control_word_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // a bus write to status may clear flags legally
  wire st_wr = avs_write && !avs_waitrequest && avs_address == `FID_ADDR_STATUS;
  wire stk_a = a_present && a_from_stack && a_tag == `FID_TAG_EMPTY;
  wire stk_b = b_present && b_from_stack && b_tag == `FID_TAG_EMPTY;
  wire any_nan = (a_present && a_class[6:5] != 2'h0) || (b_present && b_class[6:5] != 2'h0);
  a_rsp_pulse: assert property (op_valid |=> rsp_valid_r)
    else $error("no response one cycle after op");
  a_trap_commit: assert property (rsp_valid_r && rsp_trap_r |-> !rsp_commit_r
    && rsp_result_r == `FID_RES_NONE) else $error("trap with commit or result");
  a_ovf_load: assert property (op_valid && op_code == `FID_OP_LOAD
    && dst_tag != `FID_TAG_EMPTY && !stk_a |=> (status_word_r & 16'h0241) == 16'h0241)
    else $error("load overflow not flagged");
  a_undf_src: assert property (op_valid && (stk_a || stk_b) && op_code != `FID_OP_LOAD
    |=> status_word_r[6] && !status_word_r[9]) else $error("underflow not flagged");
  a_fill_xchg: assert property (op_valid && op_code == `FID_OP_XCHG && stk_a
    && control_word_r[0] |=> rsp_fill_a_r && !rsp_trap_r) else $error("no fill");
  a_flags_sticky: assert property (!st_wr |=> (status_word_r[1:0]
    & $past(status_word_r[1:0])) == $past(status_word_r[1:0])) else $error("flag lost");
  a_sf_kept: assert property (!st_wr && status_word_r[6] |=> status_word_r[6])
    else $error("stack fault flag cleared");
  a_es_set: assert property ($rose(status_word_r[0]) || $rose(status_word_r[1])
    |-> status_word_r[7]) else $error("summary flag missing");
  a_sf_inv: assert property ($rose(status_word_r[6]) |-> status_word_r[0])
    else $error("stack fault without invalid flag");
  a_eflags_unord: assert property (op_valid && control_word_r[1:0] == 2'h3
    && (op_code == `FID_OP_CMPI || op_code == `FID_OP_CMPI_P) && any_nan && !stk_a && !stk_b
    |=> rsp_eflags_wr_r && rsp_eflags_r == 3'h7) else $error("eflags not unordered");
endmodule
bind fid_exc fid_exc_props u_props (.core_clk, .reset_n, .avs_address, .avs_write,
  .avs_waitrequest, .op_valid, .op_code, .dst_tag, .a_present, .a_from_stack, .a_tag,
  .a_class, .b_present, .b_from_stack, .b_tag, .b_class,
  .rsp_valid_r, .rsp_trap_r, .rsp_commit_r, .rsp_result_r, .rsp_fill_a_r,
  .rsp_eflags_wr_r, .rsp_eflags_r, .status_word_r, .control_word_r);
`default_nettype wire

/* File: tb/fid_sw_model.sv */
// software side: avalon master for the status and control words
// assumes its task is called by one process at a time
`default_nettype none
module fid_sw_model (
  input  wire logic        core_clk,
  output var  logic [3:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata,
  output var  logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end
  // held until waitrequest low; no latency assumed
  task automatic xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data must not look valid
    avs_writedata <= ~wd;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the invalid and denormal exception unit
// assumes the software model drives the bus, this bench drives the pipeline
`include "fid_exc_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, reset_n, op_valid, load_ext, bcd_over, int_over;
  logic        avs_read, avs_write, avs_waitrequest, rv, trap, commit, norm, fa, efw;
  logic        fb, a_fs;
  logic [4:0]  op_code;
  logic [1:0]  dst_tag, a_tag, b_tag;
  logic [7:0]  a_class, b_class;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [2:0]  res, ef;
  logic [15:0] st, cw;
  int          n_fail, total_checks;
  fid_exc dut (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .op_valid, .op_code, .load_ext,
    .dst_tag, .a_present(1'b1), .a_from_stack(a_fs), .a_tag, .a_class,
    .b_present(1'b1), .b_from_stack(1'b1), .b_tag, .b_class, .bcd_over, .int_over,
    .rsp_valid_r(rv), .rsp_trap_r(trap), .rsp_commit_r(commit), .rsp_result_r(res),
    .rsp_fill_a_r(fa), .rsp_fill_b_r(fb), .rsp_normalize_r(norm), .rsp_eflags_wr_r(efw),
    .rsp_eflags_r(ef), .status_word_r(st), .control_word_r(cw));
  fid_sw_model sw (.core_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    sw.xfer(1'b1, a, {16'h0000, d}, rd);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    sw.xfer(1'b0, a, 32'h0000_0000, rd);
    chk(rd, {16'h0000, e});
  endtask
  task automatic iss(input logic [4:0] op, input logic [7:0] ac, bc,
                     input logic [1:0] at, dt, input logic le);
    @(posedge core_clk);
    op_code <= op;
    a_class <= ac;
    b_class <= bc;
    a_tag <= at;
    dst_tag <= dt;
    load_ext <= le;
    bcd_over <= (op == `FID_OP_BCD_ST);
    int_over <= (op == `FID_OP_INT_ST);
    op_valid <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    chk(rv, 1'b1);
  endtask
  task automatic mres(input logic [4:0] op, input logic [7:0] ac, bc,
                      input logic [2:0] e, input logic f);
    wr(`FID_ADDR_STATUS, 16'h00C3);
    iss(op, ac, bc, 2'h0, 2'h3, 1'b0);
    chk(res, e);
    chk(st[0], f);
    chk(commit, 1'b1);
  endtask
  task automatic t_regs;
    rdc(`FID_ADDR_STATUS, `FID_STATUS_RST);
    rdc(`FID_ADDR_CONTROL, `FID_CONTROL_RST);
    wr(4'hC, 16'hFFFF);
    rdc(4'hC, 16'h0000);
    rdc(`FID_ADDR_CONTROL, 16'h0003);
  endtask
  task automatic t_masked;
    mres(`FID_OP_ADD, 8'h10, 8'h12, 3'h1, 1'b1);
    mres(`FID_OP_SUB, 8'h10, 8'h10, 3'h1, 1'b1);
    mres(`FID_OP_MUL, 8'h10, 8'h08, 3'h1, 1'b1);
    mres(`FID_OP_DIV, 8'h10, 8'h10, 3'h1, 1'b1);
    mres(`FID_OP_DIV, 8'h08, 8'h08, 3'h1, 1'b1);
    mres(`FID_OP_ADD, 8'h80, 8'h00, 3'h1, 1'b1);
    mres(`FID_OP_ADD, 8'h40, 8'h00, 3'h2, 1'b1);
    mres(`FID_OP_SQRT, 8'h02, 8'h00, 3'h1, 1'b1);
    mres(`FID_OP_SQRT, 8'h0A, 8'h00, 3'h0, 1'b0);
    mres(`FID_OP_YL2X, 8'h02, 8'h00, 3'h1, 1'b1);
    mres(`FID_OP_YL2XP1, 8'h03, 8'h00, 3'h1, 1'b1);
    mres(`FID_OP_PREM, 8'h10, 8'h00, 3'h1, 1'b1);
    mres(`FID_OP_PREM1, 8'h00, 8'h08, 3'h1, 1'b1);
    for (int i = 13; i <= 16; i++) mres(i[4:0], 8'h10, 8'h00, 3'h1, 1'b1);
    mres(`FID_OP_BCD_ST, 8'h00, 8'h00, 3'h4, 1'b1);
    rdc(`FID_ADDR_RESP, 16'h0004);
    mres(`FID_OP_INT_ST, 8'h00, 8'h00, 3'h3, 1'b1);
    wr(`FID_ADDR_STATUS, 16'h0400);
    iss(`FID_OP_COS, 8'h10, 8'h00, 2'h0, 2'h3, 1'b0);
    chk(st[10], 1'b0);
  endtask
  task automatic t_cmp;
    wr(`FID_ADDR_CONTROL, 16'h0000);
    for (int i = 4; i <= 8; i++) begin
      iss(i[4:0], 8'h20, 8'h00, 2'h0, 2'h3, 1'b0);
      chk(trap, 1'b1);
    end
    iss(`FID_OP_UCMP, 8'h20, 8'h00, 2'h0, 2'h3, 1'b0);
    chk(trap, 1'b0);
    wr(`FID_ADDR_STATUS, 16'h00C3);
    iss(`FID_OP_ADD, 8'h20, 8'h00, 2'h0, 2'h3, 1'b0);
    chk({trap, st[0]}, 2'b00);
    wr(`FID_ADDR_CONTROL, 16'h0003);
    iss(`FID_OP_CMP, 8'h20, 8'h00, 2'h0, 2'h3, 1'b0);
    chk(st & 16'h4501, 16'h4500);
    wr(`FID_ADDR_STATUS, 16'h00C3);
    iss(`FID_OP_TEST, 8'h20, 8'h00, 2'h0, 2'h3, 1'b0);
    chk(st & 16'h4501, 16'h4500);
    iss(`FID_OP_CMPI, 8'h00, 8'h20, 2'h0, 2'h3, 1'b0);
    chk({efw, ef}, 4'hF);
  endtask
  task automatic t_stack;
    for (int t = 0; t < 3; t++) begin
      wr(`FID_ADDR_STATUS, 16'h00C3);
      iss(`FID_OP_LOAD, 8'h00, 8'h00, 2'h0, t[1:0], 1'b0);
      chk(st & 16'h0241, 16'h0241);
      chk(res, 3'h1);
    end
    wr(`FID_ADDR_STATUS, 16'h02C3);
    iss(`FID_OP_LOAD, 8'h00, 8'h00, 2'h0, 2'h3, 1'b0);
    chk(st[0], 1'b0);
    iss(`FID_OP_FP_ST, 8'h00, 8'h00, 2'h3, 2'h3, 1'b0);
    chk(st & 16'h0241, 16'h0041);
    iss(`FID_OP_INT_ST, 8'h00, 8'h00, 2'h3, 2'h3, 1'b0);
    chk(res, 3'h3);
    iss(`FID_OP_BCD_ST, 8'h00, 8'h00, 2'h3, 2'h3, 1'b0);
    chk(res, 3'h4);
    iss(`FID_OP_XCHG, 8'h00, 8'h00, 2'h3, 2'h3, 1'b0);
    chk({fa, trap}, 2'b10);
    @(posedge core_clk);
    b_tag <= 2'h3;
    a_fs <= 1'b0;
    iss(`FID_OP_XCHG, 8'h00, 8'h00, 2'h3, 2'h3, 1'b0);
    chk({fa, fb, trap}, 3'b010);
    @(posedge core_clk);
    b_tag <= 2'h0;
    a_fs <= 1'b1;
    wr(`FID_ADDR_STATUS, 16'h0081);
    iss(`FID_OP_ADD, 8'h10, 8'h12, 2'h0, 2'h3, 1'b0);
    chk(st & 16'h00C1, 16'h00C1);
    wr(`FID_ADDR_CONTROL, 16'h0000);
    iss(`FID_OP_FP_ST, 8'h00, 8'h00, 2'h3, 2'h3, 1'b0);
    chk({trap, commit, res}, 5'h10);
    rdc(`FID_ADDR_RESP, 16'h0008);
  endtask
  task automatic t_den;
    wr(`FID_ADDR_CONTROL, 16'h0003);
    wr(`FID_ADDR_STATUS, 16'h00C3);
    iss(`FID_OP_LOAD, 8'h04, 8'h00, 2'h0, 2'h3, 1'b1);
    chk(st[1], 1'b0);
    iss(`FID_OP_LOAD, 8'h04, 8'h00, 2'h0, 2'h3, 1'b0);
    chk({st[1], norm, trap}, 3'b110);
    wr(`FID_ADDR_CONTROL, 16'h0001);
    iss(`FID_OP_ADD, 8'h04, 8'h00, 2'h0, 2'h3, 1'b0);
    chk({trap, commit}, 2'b10);
    iss(`FID_OP_ADD, 8'h00, 8'h00, 2'h0, 2'h3, 1'b0);
    rdc(`FID_ADDR_STATUS, 16'h0082);
  endtask
  task automatic t_rst;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    chk({st, cw}, {`FID_STATUS_RST, `FID_CONTROL_RST});
    rdc(`FID_ADDR_CONTROL, `FID_CONTROL_RST);
  endtask
  initial begin
    reset_n = 1'b0;
    a_fs = 1'b1;
    op_valid = 1'b0;
    op_code = 5'h00;
    load_ext = 1'b0;
    bcd_over = 1'b0;
    int_over = 1'b0;
    dst_tag = 2'h3;
    a_tag = 2'h0;
    b_tag = 2'h0;
    a_class = 8'h00;
    b_class = 8'h00;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs;
    t_masked;
    t_cmp;
    t_stack;
    t_den;
    t_rst;
    report_and_stop;
  end
  // cuts a hang well past the few hundred cycles needed
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
